// [mqf_consts.svh]
`ifndef MQF_CONSTS_SVH
`define MQF_CONSTS_SVH

// queue select bus layout: [5:3] device id, [2] null queue, [1:0] queue
`define MQF_SEL_W 6
`define MQF_SEL_ID_MSB 5
`define MQF_SEL_ID_LSB 3
`define MQF_SEL_NULL_BIT 2
`define MQF_SEL_Q_MSB 1
`define MQF_SEL_Q_LSB 0
`define MQF_ID_W 3
`define MQF_MAX_QUEUES 4

// default almost-full offsets for default programming
`define MQF_DEF_OFS_SMALL 8
`define MQF_DEF_OFS_LARGE 128

// default queue depth in x18 words
`define MQF_DEF_DEPTH 8192

// byte (x9 unit) counts per word of each port width
`define MQF_UNIT_X9 2'h1
`define MQF_UNIT_X18 2'h2

// read select pipeline: new queue reaches the output on the second edge
`define MQF_RD_SWITCH_LAT 2

`endif

// [mqf_pkg.sv]
package mqf_pkg;

   // port width strap encoding
   typedef enum logic [0:0] {
      MQF_WIDTH_X18 = 1'h0,
      MQF_WIDTH_X9 = 1'h1
   } mqf_width_t;

   // read queue switch progress
   typedef enum logic [1:0] {
      MQF_RSW_IDLE = 2'h0,
      MQF_RSW_WAIT = 2'h1,
      MQF_RSW_LOAD = 2'h2
   } mqf_rsw_t;

endpackage

// [mqf_queue_level.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mqf_consts.svh"

module mqf_queue_level #(
   parameter int DEPTH = `MQF_DEF_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // configuration
   input wire logic cfg_load,
   input wire logic [$clog2(2*DEPTH+1)-1:0] cfg_offset,
   input wire logic wr_x9,
   input wire logic rd_x9,
   // traffic
   input wire logic push,
   input wire logic pop,
   // status
   output logic empty,
   output logic almost_full,
   output logic can_push
);

   localparam int CW = $clog2(2*DEPTH+1);
   localparam logic [CW-1:0] CAP = CW'(2*DEPTH);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [CW-1:0] ofs;
   } mqf_lvl_state_t;

   mqf_lvl_state_t st_q;
   mqf_lvl_state_t st_d;
   logic [CW-1:0] wunit;
   logic [CW-1:0] runit;
   logic [CW-1:0] free_b;
   logic [CW-1:0] free_w;

   // level kept in x9 units so either port width can be served
   always_comb begin
      wunit = wr_x9 ? CW'(`MQF_UNIT_X9) : CW'(`MQF_UNIT_X18);
      runit = rd_x9 ? CW'(`MQF_UNIT_X9) : CW'(`MQF_UNIT_X18);
      free_b = CAP - st_q.cnt;
      free_w = wr_x9 ? free_b : (free_b >> 1);
      empty = st_q.cnt < runit;
      almost_full = free_w <= st_q.ofs;
      can_push = free_b >= wunit;
      st_d = st_q;
      if (cfg_load) begin
         st_d.ofs = cfg_offset;
      end
      // pop and push may coincide; guards keep the count in range
      st_d.cnt = st_q.cnt + ((push && can_push) ? wunit : '0)
         - ((pop && !empty) ? runit : '0);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule
`default_nettype wire

// [mqf_flags.sv]
// Function
// - the edge that loads the output register also updates output_valid_n.
// - each queue tracks emptiness; only the read-selected queue drives it.
// - after the last word, next enabled read edge drives output_valid_n high.
// - new read queue data and its valid status appear two edges after select.
// - output_valid_n changes only on clock edges; writes change idle queues.
// - output_valid_n is released when no queue of this device is selected.
// - top three read select bits compared with device id gate the driver.
// - switching between own queues keeps driving, updating to the new queue.
// - each queue tracks almost-full; almost_full_n shows only the write-selected one.
// - each queue holds its own almost-full offset from zero to its depth.
// - default programming picks an almost-full offset of 8 or 128.
// - almost_full_n shows a new write queue on the second edge after select.
// - a write crossing the boundary drives almost_full_n low two edges later.
// - a read leaving almost-full drives almost_full_n high two edges later.
// - almost_full_n changes only on edges; reads change idle queues' status.
// - almost-full status is duplicated on a per-queue flag bus.
// - output_valid_n is active low; high marks the output word invalid.
// - almost-full counting uses words of the write port width.
// - output-valid status uses words of the read port width.
`timescale 1ns/1ps
`default_nettype none
`include "mqf_consts.svh"

module mqf_flags #(
   parameter int NUM_QUEUES = `MQF_MAX_QUEUES,
   parameter int DEPTH = `MQF_DEF_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // device straps and programming; widths and offsets sampled once after reset, device id bits used live
   input wire logic device_id_bit0,
   input wire logic device_id_bit1,
   input wire logic device_id_bit2,
   input wire logic write_width_x9,
   input wire logic read_width_x9,
   input wire logic default_program,
   input wire logic default_offset_large,
   input wire logic [NUM_QUEUES*$clog2(2*DEPTH+1)-1:0] almost_full_offsets,
   // write port
   input wire logic [`MQF_SEL_W-1:0] write_queue_select,
   input wire logic write_select_strobe,
   input wire logic write_en_n,
   // read port
   input wire logic [`MQF_SEL_W-1:0] read_queue_select,
   input wire logic read_select_strobe,
   input wire logic read_en_n,
   // flags
   output logic output_valid_n,
   output logic output_valid_oe,
   output logic almost_full_n,
   output logic [NUM_QUEUES-1:0] almost_full_bus_n,
   output logic read_pop
);

   localparam int CW = $clog2(2*DEPTH+1);
   localparam int QW = `MQF_SEL_Q_MSB - `MQF_SEL_Q_LSB + 1;

   // ==========================================================
   // elaboration checks
   if (NUM_QUEUES < 1 || NUM_QUEUES > `MQF_MAX_QUEUES) begin : g_bad_nq
      $error("NUM_QUEUES must lie between 1 and 4");
   end
   if (DEPTH < 1) begin : g_bad_depth
      $error("DEPTH must be at least 1");
   end

   // ==========================================================
   // select bus decoding
   function automatic logic id_match(input logic [`MQF_SEL_W-1:0] sel,
                                     input logic [`MQF_ID_W-1:0] id);
      id_match = sel[`MQF_SEL_ID_MSB:`MQF_SEL_ID_LSB] == id;
   endfunction

   function automatic logic [QW-1:0] queue_of(
      input logic [`MQF_SEL_W-1:0] sel);
      queue_of = sel[`MQF_SEL_Q_MSB:`MQF_SEL_Q_LSB];
   endfunction

   // a queue number beyond the configured count behaves as empty
   function automatic logic queue_ok(input logic [`MQF_SEL_W-1:0] sel);
      queue_ok = int'(queue_of(sel)) < NUM_QUEUES;
   endfunction

   // ==========================================================
   // state
   typedef struct packed {
      logic straps_done;
      logic wr_x9;
      logic rd_x9;
      mqf_pkg::mqf_rsw_t rsw;
      logic [`MQF_SEL_W-1:0] rnew;
      logic ract_live;
      logic [QW-1:0] ract;
      logic ov_n;
      logic ov_oe;
      logic wpend;
      logic [`MQF_SEL_W-1:0] wnew;
      logic wact_live;
      logic [QW-1:0] wact;
      logic paf_s1;
      logic paf_n;
      logic [NUM_QUEUES-1:0] bus_s1;
      logic [NUM_QUEUES-1:0] bus_n;
      logic pop;
   } mqf_state_t;

   mqf_state_t st_q;
   mqf_state_t st_d;

   logic [`MQF_ID_W-1:0] dev_id;
   logic cfg_load;
   logic [NUM_QUEUES-1:0] q_empty;
   logic [NUM_QUEUES-1:0] q_af;
   logic [NUM_QUEUES-1:0] q_can_push;
   logic [NUM_QUEUES-1:0] q_push;
   logic [NUM_QUEUES-1:0] q_pop;
   logic [CW-1:0] def_ofs;
   logic [CW-1:0] cap_w;

   assign dev_id = {device_id_bit2, device_id_bit1, device_id_bit0};
   // straps and offsets are taken on the first edge after reset release
   assign cfg_load = !st_q.straps_done;

   // default offsets, clamped to the write-word depth of a queue
   always_comb begin
      cap_w = write_width_x9 ? CW'(2*DEPTH) : CW'(DEPTH);
      def_ofs = default_offset_large ? CW'(`MQF_DEF_OFS_LARGE)
         : CW'(`MQF_DEF_OFS_SMALL);
      if (def_ofs > cap_w) begin
         def_ofs = cap_w;
      end
   end

   // ==========================================================
   // per-queue level trackers
   for (genvar i = 0; i < NUM_QUEUES; i++) begin : g_q
      logic [CW-1:0] ofs;
      assign ofs = default_program ? def_ofs
         : almost_full_offsets[i*CW +: CW];
      mqf_queue_level #(
         .DEPTH(DEPTH)
      ) u_level (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .cfg_load(cfg_load),
         .cfg_offset(ofs),
         .wr_x9(st_q.wr_x9),
         .rd_x9(st_q.rd_x9),
         .push(q_push[i]),
         .pop(q_pop[i]),
         .empty(q_empty[i]),
         .almost_full(q_af[i]),
         .can_push(q_can_push[i])
      );
   end

   // ==========================================================
   // next-state logic
   always_comb begin
      logic load;
      logic tgt_live;
      logic [QW-1:0] tgt;
      logic wlive_next;
      logic [QW-1:0] wq_next;
      load = 1'b0;
      tgt_live = 1'b0;
      tgt = '0;
      wlive_next = 1'b0;
      wq_next = '0;
      st_d = st_q;
      q_push = '0;
      q_pop = '0;

      // strap capture
      if (!st_q.straps_done) begin
         st_d.straps_done = 1'b1;
         st_d.wr_x9 = write_width_x9;
         st_d.rd_x9 = read_width_x9;
      end

      // ---- read side: selection pipeline
      case (st_q.rsw)
         mqf_pkg::MQF_RSW_IDLE: begin
         end
         mqf_pkg::MQF_RSW_WAIT: begin
            st_d.rsw = mqf_pkg::MQF_RSW_LOAD;
         end
         mqf_pkg::MQF_RSW_LOAD: begin
            st_d.rsw = mqf_pkg::MQF_RSW_IDLE;
         end
         default: begin
            st_d.rsw = mqf_pkg::MQF_RSW_IDLE;
         end
      endcase
      // a later select restarts the two-edge wait
      if (read_select_strobe) begin
         st_d.rnew = read_queue_select;
         st_d.rsw = mqf_pkg::MQF_RSW_WAIT;
      end

      // output register load: switch edge, enabled read or empty output
      if (st_q.rsw == mqf_pkg::MQF_RSW_LOAD) begin
         load = 1'b1;
         tgt_live = id_match(st_q.rnew, dev_id)
            && !st_q.rnew[`MQF_SEL_NULL_BIT] && queue_ok(st_q.rnew);
         tgt = queue_of(st_q.rnew);
         st_d.ract_live = tgt_live;
         st_d.ract = tgt;
         st_d.ov_oe = id_match(st_q.rnew, dev_id);
      end else begin
         load = !read_en_n || st_q.ov_n;
         tgt_live = st_q.ract_live;
         tgt = st_q.ract;
      end

      // only the active queue feeds the single valid flag
      if (load) begin
         if (tgt_live && !q_empty[tgt]) begin
            st_d.ov_n = 1'b0;
            q_pop[tgt] = 1'b1;
         end else begin
            st_d.ov_n = 1'b1;
         end
      end
      st_d.pop = |q_pop;

      // ---- write side: selection, active queue one edge later
      st_d.wpend = write_select_strobe;
      if (write_select_strobe) begin
         st_d.wnew = write_queue_select;
      end
      if (st_q.wpend) begin
         wlive_next = id_match(st_q.wnew, dev_id) && queue_ok(st_q.wnew);
         wq_next = queue_of(st_q.wnew);
      end else begin
         wlive_next = st_q.wact_live;
         wq_next = st_q.wact;
      end
      st_d.wact_live = wlive_next;
      st_d.wact = wq_next;

      // writes land in the queue active before this edge
      if (!write_en_n && st_q.wact_live && q_can_push[st_q.wact]) begin
         q_push[st_q.wact] = 1'b1;
      end

      // double-registered almost-full; first stage already follows the
      // incoming queue so the pin shows it on the second edge
      st_d.paf_s1 = wlive_next && q_af[wq_next];
      st_d.paf_n = !st_q.paf_s1;
      st_d.bus_s1 = q_af;
      st_d.bus_n = ~st_q.bus_s1;
   end

   // ==========================================================
   // state register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.ov_n <= 1'b1;
         st_q.paf_n <= 1'b1;
         st_q.bus_n <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state register
   assign output_valid_n = st_q.ov_n;
   assign output_valid_oe = st_q.ov_oe;
   assign almost_full_n = st_q.paf_n;
   assign almost_full_bus_n = st_q.bus_n;
   assign read_pop = st_q.pop;

endmodule
`default_nettype wire

// [mqf_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mqf_consts.svh"
// ==========================================
// flag port checker
module mqf_monitor #(
   parameter int NUM_QUEUES = `MQF_MAX_QUEUES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // straps and ports
   input wire logic device_id_bit0,
   input wire logic device_id_bit1,
   input wire logic device_id_bit2,
   input wire logic [`MQF_SEL_W-1:0] write_queue_select,
   input wire logic write_select_strobe,
   input wire logic write_en_n,
   input wire logic [`MQF_SEL_W-1:0] read_queue_select,
   input wire logic read_select_strobe,
   input wire logic read_en_n,
   // flags
   input wire logic output_valid_n,
   input wire logic output_valid_oe,
   input wire logic almost_full_n,
   input wire logic [NUM_QUEUES-1:0] almost_full_bus_n
);
   logic [2:0] id;
   logic rm;
   logic wm;
   // id match of each select bus
   assign id = {device_id_bit2, device_id_bit1, device_id_bit0};
   assign rm = read_queue_select[5:3] == id;
   assign wm = write_queue_select[5:3] == id;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   reset_flags_a: assert property (
      $rose(rstn) |-> output_valid_n && almost_full_n && !output_valid_oe)
      else $error("flags not idle after reset");
   ov_hold_a: assert property (
      read_en_n && !output_valid_n && !$past(read_select_strobe, 2)
      |=> !output_valid_n) else $error("valid flag moved without a load");
   oe_switch_a: assert property (
      !$past(read_select_strobe, 3) |-> $stable(output_valid_oe))
      else $error("driver enable moved outside a switch");
   oe_follow_a: assert property (
      read_select_strobe && rm ##1 !read_select_strobe [*2]
      |=> output_valid_oe) else $error("own queue not driven");
   oe_refuse_a: assert property (
      read_select_strobe && !rm ##1 !read_select_strobe [*2]
      |=> !output_valid_oe) else $error("foreign select still driven");
   null_invalid_a: assert property (
      read_select_strobe && rm && read_queue_select[2]
      ##1 !read_select_strobe [*2] |=> output_valid_n)
      else $error("null queue shows valid");
   wsel_refuse_a: assert property (
      write_select_strobe && !wm ##1 !write_select_strobe [*2]
      |=> almost_full_n) else $error("foreign write queue flagged");
   af_select_a: assert property (
      write_select_strobe && wm && write_en_n
      ##1 (!write_select_strobe && write_en_n) [*2] |=> almost_full_n
      == almost_full_bus_n[$past(write_queue_select[1:0], 3)])
      else $error("active flag differs from its bus bit");
   cover property (read_select_strobe && rm && read_queue_select[2]);
   cover property ($fell(almost_full_n));
   cover property ($fell(output_valid_n));
endmodule

bind mqf_flags mqf_monitor #(.NUM_QUEUES(NUM_QUEUES)) mon_u (
   .sys_clk(sys_clk), .rstn(rstn), .device_id_bit0(device_id_bit0),
   .device_id_bit1(device_id_bit1), .device_id_bit2(device_id_bit2),
   .write_queue_select(write_queue_select), .write_en_n(write_en_n),
   .write_select_strobe(write_select_strobe), .read_en_n(read_en_n),
   .read_queue_select(read_queue_select),
   .read_select_strobe(read_select_strobe),
   .output_valid_n(output_valid_n), .output_valid_oe(output_valid_oe),
   .almost_full_n(almost_full_n), .almost_full_bus_n(almost_full_bus_n));
`default_nettype wire

// [mqf_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mqf_consts.svh"
// ==========================================
// system controller: one read select bus, so one device read at a time
module mqf_ctrl_model (
   // clock
   input wire logic sys_clk,
   // write port
   output logic [`MQF_SEL_W-1:0] write_queue_select,
   output logic write_select_strobe,
   output logic write_en_n,
   // read port
   output logic [`MQF_SEL_W-1:0] read_queue_select,
   output logic read_select_strobe,
   output logic read_en_n
);
   // idle from time zero, selects parked on queue zero of device id zero
   initial begin
      write_queue_select = 6'h00;
      write_select_strobe = 1'b0;
      write_en_n = 1'b1;
      read_queue_select = 6'h00;
      read_select_strobe = 1'b0;
      read_en_n = 1'b1;
   end
   // write select; callers write only from the next edge on
   task automatic sel_w(logic [`MQF_SEL_W-1:0] s);
      @(posedge sys_clk);
      write_queue_select <= s;
      write_select_strobe <= 1'b1;
      @(posedge sys_clk);
      write_select_strobe <= 1'b0;
   endtask
   task automatic sel_r(logic [`MQF_SEL_W-1:0] s);
      @(posedge sys_clk);
      read_queue_select <= s;
      read_select_strobe <= 1'b1;
      @(posedge sys_clk);
      read_select_strobe <= 1'b0;
   endtask
   task automatic wr();
      @(posedge sys_clk);
      write_en_n <= 1'b0;
      @(posedge sys_clk);
      write_en_n <= 1'b1;
   endtask
   // n enabled read edges back to back
   task automatic rd(int n);
      @(posedge sys_clk);
      read_en_n <= 1'b0;
      repeat (n) @(posedge sys_clk);
      read_en_n <= 1'b1;
   endtask
   task automatic drive(logic [5:0] ws, logic wb, logic we,
                        logic [5:0] rs, logic rb, logic re);
      @(posedge sys_clk);
      write_queue_select <= ws;
      write_select_strobe <= wb;
      write_en_n <= we;
      read_queue_select <= rs;
      read_select_strobe <= rb;
      read_en_n <= re;
   endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mqf_consts.svh"
// ==========================================
// flag block bench
module testbench;
   localparam int NQ = 4;
   localparam int DP = 64;
   localparam int CW = $clog2(2*DP+1);
   localparam logic [2:0] ID = 3'h5;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic wx9 = 1'b0;
   logic rx9 = 1'b0;
   logic dprog = 1'b0;
   logic dlarge = 1'b0;
   logic [NQ*CW-1:0] ofs = {8'h00, 8'h03, 8'h02, 8'h01};
   logic [5:0] wqs, rqs;
   logic wstb, wen_n, rstb, ren_n, ov_n, oe, af_n;
   logic [NQ-1:0] afb_n;
   logic pop;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   always #5 sys_clk = ~sys_clk;
   mqf_ctrl_model ctrl_u (.sys_clk(sys_clk), .write_queue_select(wqs),
      .write_select_strobe(wstb), .write_en_n(wen_n),
      .read_queue_select(rqs), .read_select_strobe(rstb),
      .read_en_n(ren_n));
   mqf_flags #(.NUM_QUEUES(NQ), .DEPTH(DP)) dut_u (.sys_clk(sys_clk),
      .rstn(rstn), .device_id_bit0(ID[0]), .device_id_bit1(ID[1]),
      .device_id_bit2(ID[2]), .write_width_x9(wx9), .read_width_x9(rx9),
      .default_program(dprog), .default_offset_large(dlarge),
      .almost_full_offsets(ofs), .write_queue_select(wqs),
      .write_select_strobe(wstb), .write_en_n(wen_n),
      .read_queue_select(rqs), .read_select_strobe(rstb),
      .read_en_n(ren_n), .output_valid_n(ov_n), .output_valid_oe(oe),
      .almost_full_n(af_n), .almost_full_bus_n(afb_n), .read_pop(pop));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, well above the few thousand cycles the tests need
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic chk(string nm, logic e, logic s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, s);
      end
   endtask
   // sample just after an edge so its updates have landed
   task automatic at(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // offsets are in write words; default programming overrides them
   function automatic logic af_exp(int cnt, int q);
      int m;
      m = dprog ? (dlarge ? 128 : 8) : int'(ofs[q*CW+:CW]);
      return (wx9 ? 2*DP : DP) - cnt > m;
   endfunction
   task automatic do_reset(logic x9, logic dp, logic lg, logic r9);
      @(posedge sys_clk);
      rstn <= 1'b0;
      wx9 <= x9;
      rx9 <= r9;
      dprog <= dp;
      dlarge <= lg;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      at(2);
      chk("ov_n rst", 1'b1, ov_n);
      chk("af_n rst", 1'b1, af_n);
   endtask
   task automatic fill(int q);
      ctrl_u.sel_w({ID, 1'b0, q[1:0]});
      at(2);
      chk("af_n sel", af_exp(0, q), af_n);
      for (int k = 1; k <= (wx9 ? 2*DP : DP); k++) begin
         ctrl_u.wr();
         at(2);
         chk("af_n wr", af_exp(k, q), af_n);
         chk("af_bus", af_exp(k, q), afb_n[q]);
      end
   endtask
   task automatic read_test();
      ctrl_u.sel_r({ID, 1'b0, 2'h3});
      at(1);
      chk("oe early", 1'b0, oe);
      at(1);
      chk("oe sel", 1'b1, oe);
      chk("ov_n sel", 1'b0, ov_n);
      chk("pop sel", 1'b1, pop);
      at(1);
      chk("af_n hold", 1'b0, af_n);
      at(1);
      chk("af_n rise", 1'b1, af_n);
      ctrl_u.rd(DP - 1);
      #1;
      chk("ov_n last", 1'b0, ov_n);
      ctrl_u.rd(1);
      #1;
      chk("ov_n empty", 1'b1, ov_n);
      chk("pop empty", 1'b0, pop);
      ctrl_u.sel_r({ID, 1'b1, 2'h0});
      at(2);
      chk("ov_n null", 1'b1, ov_n);
      ctrl_u.sel_r({~ID, 1'b0, 2'h2});
      at(2);
      chk("oe other", 1'b0, oe);
      ctrl_u.sel_r({ID, 1'b0, 2'h2});
      ctrl_u.sel_r({ID, 1'b0, 2'h1});
      at(1);
      chk("oe switch", 1'b1, oe);
      at(1);
      chk("ov_n q1", 1'b0, ov_n);
      // a valid word must turn invalid once the null queue takes over
      ctrl_u.sel_r({ID, 1'b1, 2'h0});
      at(2);
      chk("ov_n null2", 1'b1, ov_n);
   endtask
   // x9 in, x18 out: one write is half a read word
   task automatic half_word_test();
      ctrl_u.sel_r({ID, 1'b0, 2'h0});
      ctrl_u.sel_w({ID, 1'b0, 2'h0});
      ctrl_u.wr();
      at(3);
      chk("ov_n half", 1'b1, ov_n);
      ctrl_u.wr();
      at(3);
      chk("ov_n word", 1'b0, ov_n);
   endtask
   // x18 in, x9 out: one write yields two read words
   task automatic split_word_test();
      ctrl_u.sel_r({ID, 1'b0, 2'h0});
      ctrl_u.sel_w({ID, 1'b0, 2'h0});
      ctrl_u.wr();
      at(3);
      chk("ov_n byte0", 1'b0, ov_n);
      ctrl_u.rd(1);
      #1;
      chk("ov_n byte1", 1'b0, ov_n);
      ctrl_u.rd(1);
      #1;
      chk("ov_n drained", 1'b1, ov_n);
   endtask
   task automatic rnd();
      logic [5:0] a, b;
      a = 6'($urandom);
      b = 6'($urandom);
      if (a[5]) a[5:3] = ID;
      if (b[5]) b[5:3] = ID;
      ctrl_u.drive(a, 1'($urandom % 8 == 0), 1'($urandom % 2),
                   b, 1'($urandom % 8 == 0), 1'($urandom % 2));
   endtask
   // main sequence: four programming modes, then random traffic
   initial begin
      void'($urandom(52));
      for (int md = 0; md < 4; md++) begin
         do_reset(md == 1, md > 0, md == 2, md == 3);
         if (md == 1) half_word_test();
         if (md == 3) split_word_test();
         else for (int q = 0; q < NQ; q++) fill(q);
         if (md == 0) read_test();
         $display("test mode %0d done", md);
      end
      repeat (400) rnd();
      $display("test random done");
      wrap_up();
   end
endmodule
`default_nettype wire
